// ---- design/cbs_pkg.sv ----
// constants and types for the cpu bus cycle sequencer
// Operation
// - a bus cycle is two or three states
// - on-chip memory access takes two states
// - memory data path 16 bits, byte/word
// - peripheral access two or three states
// - peripheral path 8 or 16 bits
// - 16-bit peripheral registers: word access only
// - word to 8-bit register: two cycles
// - two-state peripheral timing equals memory timing
// - cpu in one of four states
// - execution: active or subactive mode
// - halt: sleep, standby, watch, subsleep
// - writes to empty areas are dropped
// - reads from empty areas undefined
// - block move copies count bytes
// - bit instructions read, modify, write byte
// - shared address: read counter, write reload
// - port read: input pins give level
// - port read: output pins give latch
// - direction register reads all ones
package cbs_pkg;
    localparam logic [15:0] ROM_LO       = 16'h0000;
    localparam logic [15:0] ROM_HI       = 16'h7FFF;
    localparam logic [15:0] RAM_LO       = 16'hF780;
    localparam logic [15:0] RAM_HI       = 16'hFF7F;
    localparam logic [15:0] PER_LO       = 16'hFF80;
    localparam logic [15:0] ADDR_DIR     = 16'hFFE8;
    localparam logic [15:0] ADDR_PORT    = 16'hFFD8;
    localparam logic [15:0] ADDR_TIMER   = 16'hFFB0;
    localparam logic [15:0] ADDR_WIDE    = 16'hFFA0;
    localparam logic [15:0] ADDR_SLOW_LO = 16'hFFC0;
    localparam logic [15:0] ADDR_SLOW_HI = 16'hFFCF;
    localparam logic [7:0]  DIR_READ_VAL = 8'hFF;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [15:0] WORD_ZERO    = 16'h0000;
    localparam logic [1:0]  ST_FAST      = 2'h2;
    localparam logic [1:0]  ST_SLOW      = 2'h3;
    localparam int          MEM_WORDS    = 1024;
    typedef enum {CBS_RESET, CBS_EXEC, CBS_HALT, CBS_EXCEPT} cbs_cpu_e;
    typedef enum {CBS_ACTIVE_HI, CBS_ACTIVE_MED, CBS_SUBACTIVE, CBS_SLEEP_HI, CBS_SLEEP_MED,
                  CBS_STANDBY, CBS_WATCH, CBS_SUBSLEEP} cbs_mode_e;
    typedef enum {CBS_IDLE, CBS_T1, CBS_T2, CBS_T3, CBS_RMW, CBS_MOVE_RD, CBS_MOVE_WR,
                  CBS_DONE} cbs_seq_e;
    typedef enum {CBS_OP_READ, CBS_OP_WRITE, CBS_OP_BIT_SET_INSTRUCTION, CBS_OP_BIT_CLEAR_INSTRUCTION, CBS_OP_BIT_INVERT_INSTRUCTION,
                  CBS_OP_BSTORE, CBS_OP_BISTORE, CBS_OP_MOVE} cbs_op_e;
endpackage

// ---- design/cbs_sequencer.sv ----
// bus access sequencer with memory, port, timer and block move
`timescale 1ns/1ps
module cbs_sequencer
(
    input  wire logic              clk_in,
    input  wire logic              resetn_in,
    input  wire logic              state_en_in,
    input  wire logic [2:0]        mode_req_in,
    input  wire logic              mode_req_valid_in,
    input  wire logic              except_req_in,
    input  wire logic              except_done_in,
    input  wire logic              req_valid_in,
    input  wire logic [2:0]        req_op_in,
    input  wire logic [15:0]       req_addr_in,
    input  wire logic              req_word_in,
    input  wire logic [15:0]       req_wdata_in,
    input  wire logic [2:0]        req_bit_in,
    input  wire logic              req_carry_in,
    input  wire logic [15:0]       move_count_word_in,
    input  wire logic              move_count_low_byte_sel_in,
    input  wire logic [15:0]       move_source_pointer_in,
    input  wire logic [15:0]       move_destination_pointer_in,
    input  wire logic [7:0]        port_pins_in,
    input  wire logic              timer_tick_in,
    output logic                   req_ready_out,
    output logic                   done_out,
    output logic [15:0]            rdata_out,
    output logic [1:0]             cpu_state_out,
    output logic [2:0]             cpu_mode_out,
    output logic [7:0]             port_out,
    output logic [7:0]             port_oe_out,
    output logic [7:0]             timer_count_out,
    output logic [1:0]             bus_state_out,
    output logic                   bus_cycle_out
);
    import cbs_pkg::*;

    cbs_cpu_e        cpu_r;
    cbs_mode_e       mode_r;
    cbs_seq_e        seq_r;
    cbs_op_e         op_r;
    logic [15:0]     addr_r;
    logic [15:0]     wdata_r;
    logic            word_r;
    logic            second_r;
    logic [2:0]      bit_r;
    logic            carry_r;
    logic            rmw_wr_r;
    logic [7:0]      rmw_byte_r;
    logic [15:0]     move_src_r;
    logic [15:0]     move_dst_r;
    logic [15:0]     move_cnt_r;
    logic [7:0]      move_byte_r;
    logic [15:0]     rdata_r;
    logic            done_r;
    logic [7:0]      port_direction_register_r;
    logic [7:0]      port_output_latch_register_r;
    logic [7:0]      reload_r;
    logic [7:0]      count_r;
    logic [15:0]     wide_r;
    logic [15:0]     mem_r [0:MEM_WORDS-1];
    logic            in_rom;
    logic            in_ram;
    logic            in_per;
    logic            slow;
    logic            eight_bit;
    logic [7:0]      rd_byte;
    logic [7:0]      mod_byte;
    logic            wr_en;
    logic            wr_word;
    logic [15:0]     wr_val;
    logic [15:0]     cur_addr;
    logic [9:0]      mem_idx;
    logic            last_state;

    // area decode of the current address
    always_comb
    begin
        in_rom    = (cur_addr <= ROM_HI);
        in_ram    = (cur_addr >= RAM_LO) && (cur_addr <= RAM_HI);
        in_per    = (cur_addr >= PER_LO);
        slow      = in_per && (cur_addr >= ADDR_SLOW_LO) && (cur_addr <= ADDR_SLOW_HI);
        eight_bit = in_per && (cur_addr[15:1] != ADDR_WIDE[15:1]);
        mem_idx   = cur_addr[10:1];
    end

    // byte read path for registers, ports and memory
    always_comb
    begin
        rd_byte = BYTE_ZERO;
        if (cur_addr == ADDR_PORT)
        begin
            rd_byte = (port_direction_register_r & port_output_latch_register_r)
                    | (~port_direction_register_r & port_pins_in);
        end
        else if (cur_addr == ADDR_DIR)
        begin
            rd_byte = DIR_READ_VAL;
        end
        else if (cur_addr == ADDR_TIMER)
        begin
            rd_byte = count_r;
        end
        else if (cur_addr[15:1] == ADDR_WIDE[15:1])
        begin
            rd_byte = cur_addr[0] ? wide_r[7:0] : wide_r[15:8];
        end
        else if (in_rom || in_ram)
        begin
            rd_byte = cur_addr[0] ? mem_r[mem_idx][7:0] : mem_r[mem_idx][15:8];
        end
        else
        begin
            rd_byte = BYTE_ZERO;
        end
    end

    // bit modification for read-modify-write instructions
    always_comb
    begin
        mod_byte = rmw_byte_r;
        case (op_r)
            CBS_OP_BIT_SET_INSTRUCTION:    mod_byte[bit_r] = 1'b1;
            CBS_OP_BIT_CLEAR_INSTRUCTION:    mod_byte[bit_r] = 1'b0;
            CBS_OP_BIT_INVERT_INSTRUCTION:    mod_byte[bit_r] = ~rmw_byte_r[bit_r];
            CBS_OP_BSTORE:  mod_byte[bit_r] = carry_r;
            CBS_OP_BISTORE: mod_byte[bit_r] = ~carry_r;
            default:        mod_byte = rmw_byte_r;
        endcase
    end

    // address, write enable and data of the cycle in progress
    always_comb
    begin
        cur_addr = addr_r;
        wr_en    = 1'b0;
        wr_word  = 1'b0;
        wr_val   = wdata_r;
        if (op_r == CBS_OP_MOVE)
        begin
            cur_addr = (seq_r == CBS_MOVE_WR) ? move_dst_r : move_src_r;
            wr_en    = (seq_r == CBS_MOVE_WR);
            wr_val   = {move_byte_r, move_byte_r};
        end
        else if (op_r == CBS_OP_WRITE)
        begin
            cur_addr = second_r ? (addr_r + 16'h0001) : addr_r;
            wr_en    = 1'b1;
            wr_word  = word_r && !eight_bit;
            // byte data sits in the low bits, copied to both lanes
            wr_val   = (word_r && eight_bit && !second_r) ? {wdata_r[15:8], wdata_r[15:8]}
                     : (word_r && !eight_bit) ? wdata_r : {wdata_r[7:0], wdata_r[7:0]};
        end
        else if (op_r != CBS_OP_READ)
        begin
            wr_en  = rmw_wr_r;
            wr_val = {mod_byte, mod_byte};
        end
    end

    assign last_state = slow ? (seq_r == CBS_T3) : (seq_r == CBS_T2);

    // access sequencer, states advance on the clock enable
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            seq_r <= CBS_IDLE;
            op_r <= CBS_OP_READ;
            addr_r <= WORD_ZERO;
            wdata_r <= WORD_ZERO;
            word_r <= 1'b0;
            second_r <= 1'b0;
            bit_r <= 3'h0;
            carry_r <= 1'b0;
            rmw_wr_r <= 1'b0;
            rmw_byte_r <= BYTE_ZERO;
            move_src_r <= WORD_ZERO;
            move_dst_r <= WORD_ZERO;
            move_cnt_r <= WORD_ZERO;
            move_byte_r <= BYTE_ZERO;
            rdata_r <= WORD_ZERO;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= 1'b0;
            if (state_en_in)
            begin
                case (seq_r)
                    CBS_IDLE:
                    begin
                        if (req_valid_in && cpu_r == CBS_EXEC)
                        begin
                            op_r     <= cbs_op_e'(req_op_in);
                            addr_r   <= req_addr_in;
                            wdata_r  <= req_wdata_in;
                            word_r   <= req_word_in;
                            bit_r    <= req_bit_in;
                            carry_r  <= req_carry_in;
                            second_r <= 1'b0;
                            rmw_wr_r <= 1'b0;
                            move_cnt_r <= move_count_low_byte_sel_in
                                        ? {8'h00, move_count_word_in[7:0]} : move_count_word_in;
                            move_src_r <= move_source_pointer_in;
                            move_dst_r <= move_destination_pointer_in;
                            seq_r <= (cbs_op_e'(req_op_in) == CBS_OP_MOVE) ? CBS_MOVE_RD
                                   : CBS_T1;
                        end
                    end
                    CBS_T1:
                        seq_r <= CBS_T2;
                    CBS_T2, CBS_T3:
                    begin
                        if (!last_state)
                            seq_r <= CBS_T3;
                        else if (op_r == CBS_OP_READ || op_r == CBS_OP_WRITE)
                        begin
                            if (op_r == CBS_OP_READ && word_r && !eight_bit)
                                rdata_r <= (cur_addr[15:1] == ADDR_WIDE[15:1]) ? wide_r
                                         : (in_rom || in_ram) ? {rd_byte, mem_r[mem_idx][7:0]}
                                         : {rd_byte, BYTE_ZERO};
                            else if (second_r)
                                rdata_r <= {rdata_r[7:0], rd_byte};
                            else
                                rdata_r <= {8'h00, rd_byte};
                            if (word_r && eight_bit && !second_r)
                            begin
                                second_r <= 1'b1;
                                seq_r    <= CBS_T1;
                            end
                            else
                                seq_r <= CBS_DONE;
                        end
                        else if (!rmw_wr_r)
                        begin
                            rmw_byte_r <= rd_byte;
                            rmw_wr_r   <= 1'b1;
                            seq_r      <= CBS_T1;
                        end
                        else
                        begin
                            rdata_r <= {8'h00, mod_byte};
                            seq_r   <= CBS_DONE;
                        end
                    end
                    CBS_MOVE_RD:
                    begin
                        if (move_cnt_r == WORD_ZERO)
                            seq_r <= CBS_DONE;
                        else
                        begin
                            move_byte_r <= rd_byte;
                            seq_r       <= CBS_MOVE_WR;
                        end
                    end
                    CBS_MOVE_WR:
                    begin
                        move_src_r <= move_src_r + 16'h0001;
                        move_dst_r <= move_dst_r + 16'h0001;
                        move_cnt_r <= move_cnt_r - 16'h0001;
                        seq_r      <= CBS_MOVE_RD;
                    end
                    default:
                    begin
                        done_r <= 1'b1;
                        seq_r  <= CBS_IDLE;
                    end
                endcase
            end
        end
    end

    // storage updates; empty areas store nothing
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            port_direction_register_r    <= BYTE_ZERO;
            port_output_latch_register_r <= BYTE_ZERO;
            reload_r <= BYTE_ZERO;
            wide_r   <= WORD_ZERO;
        end
        else if (state_en_in && wr_en && (last_state || seq_r == CBS_MOVE_WR))
        begin
            if (cur_addr == ADDR_PORT)
                port_output_latch_register_r <= wr_val[7:0];
            else if (cur_addr == ADDR_DIR)
                port_direction_register_r <= wr_val[7:0];
            else if (cur_addr == ADDR_TIMER)
                reload_r <= wr_val[7:0];
            else if (cur_addr[15:1] == ADDR_WIDE[15:1] && wr_word)
                wide_r <= wr_val;
        end
    end

    // on-chip ram store, byte lanes by address bit 0
    always_ff @(posedge clk_in)
    begin
        if (state_en_in && wr_en && in_ram && (last_state || seq_r == CBS_MOVE_WR))
        begin
            if (wr_word || !cur_addr[0])
                mem_r[mem_idx][15:8] <= wr_val[15:8];
            if (wr_word || cur_addr[0])
                mem_r[mem_idx][7:0] <= wr_val[7:0];
        end
    end

    // reloadable up counter sharing the timer address
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            count_r <= BYTE_ZERO;
        else if (timer_tick_in)
            count_r <= (count_r == 8'hFF) ? reload_r : count_r + 8'h01;
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cpu_r  <= CBS_RESET;
            mode_r <= CBS_ACTIVE_HI;
        end
        else
        begin
            case (cpu_r)
                CBS_RESET:
                    cpu_r <= CBS_EXCEPT;
                CBS_EXCEPT:
                    if (except_done_in)
                        cpu_r <= CBS_EXEC;
                CBS_EXEC:
                    if (except_req_in && seq_r == CBS_IDLE)
                        cpu_r <= CBS_EXCEPT;
                    else if (mode_req_valid_in && seq_r == CBS_IDLE)
                    begin
                        mode_r <= cbs_mode_e'(mode_req_in);
                        cpu_r  <= (mode_req_in >= 3'h3) ? CBS_HALT : CBS_EXEC;
                    end
                default:
                    if (except_req_in)
                        cpu_r <= CBS_EXCEPT;
                    else if (mode_req_valid_in && mode_req_in < 3'h3)
                    begin
                        mode_r <= cbs_mode_e'(mode_req_in);
                        cpu_r  <= CBS_EXEC;
                    end
            endcase
        end
    end

    // outputs
    assign req_ready_out   = (seq_r == CBS_IDLE) && (cpu_r == CBS_EXEC);
    assign done_out        = done_r;
    assign rdata_out       = rdata_r;
    assign cpu_state_out   = 2'(cpu_r);
    assign cpu_mode_out    = 3'(mode_r);
    assign port_out        = port_output_latch_register_r;
    assign port_oe_out     = port_direction_register_r;
    assign timer_count_out = count_r;
    assign bus_state_out   = slow ? ST_SLOW : ST_FAST;
    assign bus_cycle_out   = (seq_r == CBS_T1) || (seq_r == CBS_T2) || (seq_r == CBS_T3);
endmodule

// ---- testbench/cbs_sequencer_props.sv ----
// concurrent checks on the bus sequencer ports
`timescale 1ns/1ps
module cbs_sequencer_props
    import cbs_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        resetn_in,
    input wire logic        state_en_in,
    input wire logic [2:0]  mode_req_in,
    input wire logic        mode_req_valid_in,
    input wire logic        except_req_in,
    input wire logic        req_valid_in,
    input wire logic [2:0]  req_op_in,
    input wire logic [15:0] req_addr_in,
    input wire logic        req_word_in,
    input wire logic [15:0] req_wdata_in,
    input wire logic [7:0]  port_pins_in,
    input wire logic        req_ready_out,
    input wire logic        done_out,
    input wire logic [15:0] rdata_out,
    input wire logic [1:0]  cpu_state_out,
    input wire logic [2:0]  cpu_mode_out,
    input wire logic [7:0]  port_out,
    input wire logic [7:0]  port_oe_out
);
    logic        take;
    logic        rd_now;
    logic        slow_a;
    logic [15:0] addr_r;
    logic [2:0]  op_r;
    logic        word_r;
    logic [7:0]  wd_r;
    logic        rd_r;
    // request decode at the taking edge
    assign take = state_en_in && req_valid_in && req_ready_out;
    assign rd_now = take && req_op_in == 3'h0 && !req_word_in;
    assign slow_a = req_addr_in >= ADDR_SLOW_LO && req_addr_in <= ADDR_SLOW_HI;
    assign rd_r = op_r == 3'h0 && !word_r;
    // remember the request in flight
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            addr_r <= WORD_ZERO;
            op_r <= 3'h0;
            word_r <= 1'b0;
            wd_r <= BYTE_ZERO;
        end
        else if (take)
        begin
            addr_r <= req_addr_in;
            op_r <= req_op_in;
            word_r <= req_word_in;
            wd_r <= req_wdata_in[7:0];
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    a_ready_in_exec: assert property (req_ready_out |-> cpu_state_out == 2'h1)
        else $error("request accepted outside execution");
    a_fast_read: assert property (rd_now && !slow_a ##1 state_en_in [*3] |->
        !done_out ##1 done_out)
        else $error("two-state read ends at wrong time");
    a_slow_read: assert property (rd_now && slow_a ##1 state_en_in [*4] |->
        !done_out ##1 done_out)
        else $error("three-state read ends at wrong time");
    a_word_split: assert property (take && req_word_in && req_addr_in == ADDR_PORT
        ##1 state_en_in [*3] |=> !done_out)
        else $error("word access to byte register done in one cycle");
    a_bitop_two: assert property (take && req_op_in inside {[3'h2:3'h6]}
        ##1 state_en_in [*3] |=> !done_out)
        else $error("bit operation done in one cycle");
    a_dir_ones: assert property (done_out && rd_r && addr_r == ADDR_DIR |->
        rdata_out[7:0] == DIR_READ_VAL)
        else $error("direction read not all ones");
    a_port_mix: assert property (done_out && rd_r && addr_r == ADDR_PORT |->
        rdata_out[7:0] == ((port_oe_out & port_out) | (~port_oe_out & port_pins_in)))
        else $error("port read mixes pins and latch wrongly");
    a_dir_to_oe: assert property (done_out && op_r == 3'h1 && !word_r
        && addr_r == ADDR_DIR |-> port_oe_out == wd_r)
        else $error("direction write not on enables");
    a_mode_apply: assert property (mode_req_valid_in && !except_req_in
        && (req_ready_out || (cpu_state_out == 2'h2 && mode_req_in < 3'h3))
        |=> cpu_mode_out == $past(mode_req_in))
        else $error("mode request not applied");
endmodule
bind cbs_sequencer cbs_sequencer_props cbs_sequencer_props_i (.clk_in, .resetn_in, .state_en_in,
    .mode_req_in, .mode_req_valid_in, .req_valid_in, .req_op_in, .req_addr_in, .req_word_in,
    .req_wdata_in, .port_pins_in, .req_ready_out, .done_out, .rdata_out, .cpu_state_out,
    .cpu_mode_out, .port_out, .port_oe_out, .except_req_in);

// ---- testbench/cbs_pin_model.sv ----
// board model: port pin levels and timer tick source
`timescale 1ns/1ps
module cbs_pin_model
(
    input  wire logic       clk_in,
    input  wire logic [7:0] port_out_in,
    input  wire logic [7:0] port_oe_in,
    input  wire logic [7:0] ext_level_in,
    input  wire logic       tick_run_in,
    output logic [7:0]      pins_out,
    output logic            tick_out
);
    assign pins_out = (port_oe_in & port_out_in) | (~port_oe_in & ext_level_in);
    // ticks change off the sampling edge
    always_ff @(negedge clk_in)
    begin
        tick_out <= tick_run_in;
    end
endmodule

// ---- testbench/cbs_sequencer_test.sv ----
// self-checking bench for the bus access sequencer
`timescale 1ns/1ps
module cbs_sequencer_test;
    import cbs_pkg::*;
    localparam logic [2:0] BOP [5] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
    localparam logic [2:0] BBIT [5] = '{3'h0, 3'h7, 3'h1, 3'h0, 3'h3};
    localparam logic [7:0] BEXP [5] = '{8'h81, 8'h01, 8'h03, 8'h02, 8'h0A};
    logic clk_in = 1'b0, resetn_in = 1'b0, state_en_in = 1'b1, en_div = 1'b0;
    logic mode_req_valid_in = 1'b0, except_req_in = 1'b0, except_done_in = 1'b0;
    logic req_valid_in = 1'b0, req_word_in = 1'b0, req_carry_in = 1'b0, tick_run = 1'b0;
    logic [2:0] mode_req_in = 3'h0, req_op_in = 3'h0, req_bit_in = 3'h0;
    logic [15:0] req_addr_in = 16'h0000, req_wdata_in = 16'h0000, q, n, f;
    logic move_count_low_byte_sel_in = 1'b1;
    logic [15:0] move_count_word_in = 16'h0103, move_source_pointer_in = 16'hF7A0;
    logic [15:0] move_destination_pointer_in = 16'hF7B0;
    logic [7:0] ext = 8'h40, port_pins_in, port_out, port_oe_out, timer_count_out;
    logic timer_tick_in, req_ready_out, done_out, bus_cycle_out;
    logic [1:0] cpu_state_out, bus_state_out;
    logic [2:0] cpu_mode_out;
    logic [15:0] rdata_out;
    int fail_count = 0, check_count = 0, cyc = 0;
    cbs_sequencer cbs_sequencer_i (.clk_in, .resetn_in, .state_en_in, .mode_req_in,
        .mode_req_valid_in, .except_req_in, .except_done_in, .req_valid_in, .req_op_in,
        .req_addr_in, .req_word_in, .req_wdata_in, .req_bit_in, .req_carry_in,
        .move_count_word_in, .move_count_low_byte_sel_in, .move_source_pointer_in,
        .move_destination_pointer_in, .port_pins_in, .timer_tick_in, .req_ready_out,
        .done_out, .rdata_out, .cpu_state_out, .cpu_mode_out, .port_out, .port_oe_out,
        .timer_count_out, .bus_state_out, .bus_cycle_out);
    cbs_pin_model cbs_pin_model_i (.clk_in, .port_out_in(port_out), .port_oe_in(port_oe_out),
        .ext_level_in(ext), .tick_run_in(tick_run), .pins_out(port_pins_in),
        .tick_out(timer_tick_in));
    // clock and state enable, subclock rate when en_div is set
    always #20 clk_in = ~clk_in;
    always @(negedge clk_in) state_en_in <= en_div ? ~state_en_in : 1'b1;
    // hang guard
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            final_report();
        end
    end
    task final_report;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task step;
        @(negedge clk_in);
        #1;
    endtask
    // one request held until taken, then wait for the done pulse
    task req(input logic [2:0] op, input logic [15:0] a, input logic w,
             input logic [15:0] d, input logic [2:0] b);
        step();
        req_op_in = op;
        req_addr_in = a;
        req_word_in = w;
        req_wdata_in = d;
        req_bit_in = b;
        req_valid_in = 1'b1;
        for (int k = 0; k < 60 && !(req_ready_out === 1'b1 && state_en_in === 1'b1); k++)
            step();
        step();
        req_valid_in = 1'b0;
        n = 16'h0001;
        while (done_out !== 1'b1 && n < 16'h0040)
        begin
            step();
            n++;
        end
        check(done_out, 1'b1);
        q = rdata_out;
    endtask
    // one mode request held for a single clock edge
    task mode_set(input logic [2:0] m);
        step();
        mode_req_in = m;
        mode_req_valid_in = 1'b1;
        step();
        mode_req_valid_in = 1'b0;
    endtask
    task t_reset;
        repeat (5) @(posedge clk_in);
        #1 check(cpu_state_out, 2'h0);
        check(port_oe_out, 8'h00);
        step();
        resetn_in = 1'b1;
        step();
        step();
        check(cpu_state_out, 2'h3);
        except_done_in = 1'b1;
        step();
        except_done_in = 1'b0;
        for (int k = 0; k < 20 && req_ready_out !== 1'b1; k++)
            step();
        check(cpu_state_out, 2'h1);
    endtask
    task t_mem;
        req(3'h1, 16'hF780, 1'b1, 16'h1234, 3'h0);
        req(3'h1, 16'hF781, 1'b0, 16'h00AB, 3'h0);
        req(3'h0, 16'hF780, 1'b1, WORD_ZERO, 3'h0);
        check(q, 16'h12AB);
        req(3'h0, 16'hF781, 1'b0, WORD_ZERO, 3'h0);
        check(q[7:0], 8'hAB);
        f = n;
        req(3'h0, ADDR_DIR, 1'b0, WORD_ZERO, 3'h0);
        check(n, f);
        req(3'h0, ADDR_SLOW_LO, 1'b0, WORD_ZERO, 3'h0);
        check(n, f + 16'h0001);
        req(3'h0, ADDR_PORT, 1'b1, WORD_ZERO, 3'h0);
        check(n, f + 16'h0002);
        req(3'h1, ADDR_WIDE, 1'b1, 16'h5A5A, 3'h0);
        req(3'h1, ADDR_WIDE, 1'b0, 16'h0033, 3'h0);
        req(3'h0, ADDR_WIDE, 1'b1, WORD_ZERO, 3'h0);
        check(q, 16'h5A5A);
        req(3'h1, 16'h8000, 1'b1, 16'hBEEF, 3'h0);
        req(3'h0, 16'h8000, 1'b1, WORD_ZERO, 3'h0);
        check(q, WORD_ZERO);
    endtask
    task t_port;
        req(3'h1, ADDR_DIR, 1'b0, 16'h003F, 3'h0);
        check(port_oe_out, 8'h3F);
        req(3'h1, ADDR_PORT, 1'b0, 16'h0080, 3'h0);
        req(3'h0, ADDR_PORT, 1'b0, WORD_ZERO, 3'h0);
        check(q[7:0], 8'h40);
        req(3'h2, ADDR_PORT, 1'b0, WORD_ZERO, 3'h0);
        check(port_out, 8'h41);
        req(3'h0, ADDR_DIR, 1'b0, WORD_ZERO, 3'h0);
        check(q[7:0], DIR_READ_VAL);
        req(3'h3, ADDR_DIR, 1'b0, WORD_ZERO, 3'h0);
        check(port_oe_out, 8'hFE);
        req(3'h0, ADDR_PORT, 1'b0, WORD_ZERO, 3'h0);
        check(q[7:0], 8'h40);
        // bit work on a shadow copy in ram, then whole byte out
        req(3'h1, 16'hF7C0, 1'b0, 16'h0080, 3'h0);
        for (int i = 0; i < 5; i++)
        begin
            req(BOP[i], 16'hF7C0, 1'b0, WORD_ZERO, BBIT[i]);
            req(3'h0, 16'hF7C0, 1'b0, WORD_ZERO, 3'h0);
            check(q[7:0], BEXP[i]);
        end
        req(3'h1, ADDR_PORT, 1'b0, {8'h00, q[7:0]}, 3'h0);
        check(port_out, 8'h0A);
    endtask
    task t_timer_move;
        step();
        tick_run = 1'b1;
        repeat (3) step();
        tick_run = 1'b0;
        repeat (2) step();
        check(timer_count_out, 8'h03);
        req(3'h2, ADDR_TIMER, 1'b0, WORD_ZERO, 3'h7);
        check(timer_count_out, 8'h03);
        req(3'h0, ADDR_TIMER, 1'b0, WORD_ZERO, 3'h0);
        check(q[7:0], 8'h03);
        // overflow after 253 ticks must load the written value 83
        tick_run = 1'b1;
        repeat (253) step();
        tick_run = 1'b0;
        repeat (2) step();
        check(timer_count_out, 8'h83);
        req(3'h1, 16'hF7A0, 1'b1, 16'h1122, 3'h0);
        req(3'h1, 16'hF7A2, 1'b1, 16'h3344, 3'h0);
        req(3'h1, 16'hF7B2, 1'b1, 16'h00EE, 3'h0);
        // destination end stays well below the top
        req(3'h7, WORD_ZERO, 1'b0, WORD_ZERO, 3'h0);
        req(3'h0, 16'hF7B0, 1'b1, WORD_ZERO, 3'h0);
        check(q, 16'h1122);
        req(3'h0, 16'hF7B2, 1'b1, WORD_ZERO, 3'h0);
        check(q, 16'h33EE);
    endtask
    task t_mode;
        // halt modes are left through active mode before the next one
        for (int i = 0; i < 8; i++)
        begin
            mode_set(i[2:0]);
            check(cpu_mode_out, i[2:0]);
            check(cpu_state_out, (i > 2) ? 2'h2 : 2'h1);
            mode_set(3'h0);
            check(cpu_state_out, 2'h1);
        end
        except_req_in = 1'b1;
        step();
        except_req_in = 1'b0;
        step();
        check(cpu_state_out, 2'h3);
        except_done_in = 1'b1;
        step();
        except_done_in = 1'b0;
        step();
        check(cpu_state_out, 2'h1);
        en_div = 1'b1;
        req(3'h0, 16'hF781, 1'b0, WORD_ZERO, 3'h0);
        check(q[7:0], 8'hAB);
        check(n, f + 16'h0003);
        en_div = 1'b0;
    endtask
    // main sequence
    initial
    begin
        t_reset();
        t_mem();
        t_port();
        t_timer_move();
        t_mode();
        final_report();
    end
endmodule
